//--- verif/ppsel_checker.sv
// Concurrent checks on the link between the configuration host and the device
`timescale 1ns/1ns
`default_nettype none
module ppsel_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Link signals
    input wire logic        cfg_req,
    input wire logic        cfg_we,
    input wire logic [7:0]  cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_ack,
    input wire logic        pme_n,
    input wire logic        pci_oe
);
    logic d3_reg;
    logic en_reg;
    // Decode of accesses to the control/status word
    wire csr_wr = cfg_req && cfg_we && (cfg_addr == 8'h44);
    wire ps_ok  = (cfg_wdata[1:0] == 2'h0) || (cfg_wdata[1:0] == 2'h3);
    wire csr_rd = cfg_ack && !cfg_we && (cfg_addr == 8'h44);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of state and enable; unsupported codes must not move the state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            d3_reg <= 1'b0;
            en_reg <= 1'b0;
        end
        else if (csr_wr)
        begin
            en_reg <= cfg_wdata[8];
            if (ps_ok)
                d3_reg <= cfg_wdata[1];
        end
    end
    property p_ack_next; cfg_req && !cfg_ack |=> cfg_ack; endproperty
    a_ack_next: assert property (p_ack_next) else $error("config access unanswered");
    property p_ack_pulse; cfg_ack |=> !cfg_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
    property p_cap; cfg_ack && !cfg_we && cfg_addr == 8'h40 |-> cfg_rdata == 32'h400a_0001;
    endproperty
    a_cap: assert property (p_cap) else $error("capability word wrong");
    property p_csr_zero;
        csr_rd |-> cfg_rdata[31:16] == 16'h0 && cfg_rdata[14:9] == 6'h0 && cfg_rdata[7:2] == 6'h0;
    endproperty
    a_csr_zero: assert property (p_csr_zero) else $error("reserved csr bits set");
    property p_ps_read; csr_rd |-> cfg_rdata[1:0] == {2{d3_reg}} && cfg_rdata[8] == en_reg;
    endproperty
    a_ps_read: assert property (p_ps_read) else $error("state or enable readback");
    property p_pme_cause; !pme_n |-> d3_reg && en_reg; endproperty
    a_pme_cause: assert property (p_pme_cause) else $error("wake out of place");
    property p_oe_exit; csr_wr && d3_reg && cfg_wdata[1:0] == 2'h0 |=> !pci_oe; endproperty
    a_oe_exit: assert property (p_oe_exit) else $error("drivers on at exit");
    property p_oe_back; !pci_oe |-> ##[1:8] pci_oe; endproperty
    a_oe_back: assert property (p_oe_back) else $error("drivers stay off");
    property p_reset_idle; $rose(presetn) |-> pme_n && pci_oe && !cfg_ack; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle");
endmodule
`default_nettype wire

//--- verif/ppsel_tb.sv
// Self-checking bench: APB drives the host end, which talks to the device end
`timescale 1ns/1ns
`default_nettype none
module ppsel_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic [3:0]  rx_pin;
    logic [15:0] modem_delta;
    logic        int_req;
    logic        inta_n;
    logic        func_enable;
    logic        sk_q;
    logic [24:0] di_cap;
    int          n_rises = 0;
    logic        eeprom_select_pin;
    logic        rom_cs;
    logic        rom_sk;
    logic        rom_di;
    logic        rom_do;
    logic        load_done;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // Plain reads after reset: offset beside expected word
    typedef struct { logic [7:0] a; logic [31:0] e; } ppsel_row_type;
    ppsel_row_type rows [6] = '{'{8'h40, 32'h400a_0001}, '{8'h44, 32'h0}, '{8'h48, 32'h0},
        '{8'h00, 32'h5678_1234}, '{8'h08, 32'h0700_0201}, '{8'h2c, 32'h0}};
    ppsel_if link ();
    ppsel_host i_ppsel_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dev(link));
    ppsel_device i_ppsel_device (.pclk(pclk), .presetn(presetn), .bus(link), .rx_pin(rx_pin),
        .modem_delta(modem_delta), .int_req(int_req), .inta_n(inta_n), .func_enable(func_enable),
        .eeprom_select_pin(eeprom_select_pin), .rom_cs(rom_cs), .rom_sk(rom_sk),
        .rom_di(rom_di), .rom_do(rom_do), .load_done(load_done));
    ppsel_checker i_ppsel_checker (.pclk(pclk), .presetn(presetn), .cfg_req(link.cfg_req),
        .cfg_we(link.cfg_we), .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata),
        .cfg_rdata(link.cfg_rdata), .cfg_ack(link.cfg_ack), .pme_n(link.pme_n),
        .pci_oe(link.pci_oe));
    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Hang guard, far above a full download plus traffic
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    // Serial clock watch: counts rises and keeps the last 25 data-in bits
    always @(posedge pclk)
    begin
        sk_q <= rom_sk;
        if (rom_sk && !sk_q)
        begin
            n_rises++;
            di_cap <= {di_cap[23:0], rom_di};
        end
    end
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        check32({31'h0, got}, {31'h0, exp});
    endtask
    // One APB transfer; entered just after a rising edge, holds until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Configuration access through the host's registers; busy is polled
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, 12'h004, {24'h0, a});
        apb(1'b1, 12'h008, d);
        apb(1'b1, 12'h000, {31'h0, wr});
        do apb(1'b0, 12'h010, 32'h0); while (rd[0] !== 1'b0);
        if (!wr)
            apb(1'b0, 12'h00c, 32'h0);
    endtask
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        rx_pin = 4'hf;
        modem_delta = 16'h0;
        int_req = 1'b0;
        eeprom_select_pin = 1'b0;
        rom_do = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i])
        begin
            cfg(1'b0, rows[i].a, 32'h0);
            check32(rd, rows[i].e);
        end
        apb(1'b0, 12'h020, 32'h0);
        check1(err, 1'b1);
        int_req <= 1'b1;
        cfg(1'b1, 8'h48, 32'hffff_ffff);
        cfg(1'b0, 8'h48, 32'h0);
        check32(rd, 32'h0);
        check1(inta_n, 1'b0);
        // Memory probe is answered in D0
        apb(1'b1, 12'h000, 32'h0000_0002);
        apb(1'b0, 12'h010, 32'h0);
        check1(rd[3], 1'b1);
        // Unsupported code 2 must leave the state alone
        cfg(1'b1, 8'h44, 32'h0000_0102);
        cfg(1'b0, 8'h44, 32'h0);
        check32(rd, 32'h0000_0100);
        cfg(1'b1, 8'h44, 32'h0000_0103);
        cfg(1'b0, 8'h44, 32'h0);
        check32(rd, 32'h0000_0103);
        check1(inta_n, 1'b1);
        check1(func_enable, 1'b1);
        // Memory probe goes unanswered in D3hot
        apb(1'b1, 12'h000, 32'h0000_0002);
        apb(1'b0, 12'h010, 32'h0);
        check1(rd[3], 1'b0);
        // Start bit on channel 2 while asleep and enabled
        rx_pin <= 4'hb;
        for (int i = 0; i < 20 && link.pme_n !== 1'b0; i++) @(posedge pclk);
        check1(link.pme_n, 1'b0);
        rx_pin <= 4'hf;
        cfg(1'b1, 8'h44, 32'h0000_8103);
        cfg(1'b0, 8'h44, 32'h0);
        check32(rd, 32'h0000_0103);
        check1(link.pme_n, 1'b1);
        // Modem delta with wake disabled still sets the flag
        cfg(1'b1, 8'h44, 32'h0000_0003);
        modem_delta <= 16'h0200;
        @(posedge pclk);
        modem_delta <= 16'h0;
        cfg(1'b0, 8'h44, 32'h0);
        check32(rd, 32'h0000_8003);
        check1(link.pme_n, 1'b1);
        cfg(1'b1, 8'h44, 32'h0000_8100);
        cfg(1'b0, 8'h44, 32'h0);
        check32(rd, 32'h0000_0100);
        cfg(1'b0, 8'h00, 32'h0);
        check32(rd, 32'h5678_1234);
        // Second power-up with the ROM strapped in; an erased part reads all ones
        presetn <= 1'b0;
        eeprom_select_pin <= 1'b1;
        rom_do <= 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 65536 && load_done !== 1'b1; i++) @(posedge pclk);
        check1(load_done, 1'b1);
        check32(n_rises, 32'h0000_00c8);
        check32({7'h00, di_cap}, 32'h0187_0000);
        cfg(1'b0, 8'h48, 32'h0);
        check32(rd, 32'hffff_ffff);
        cfg(1'b0, 8'h08, 32'h0);
        check32(rd, 32'hffff_ff01);
        cfg(1'b0, 8'h2c, 32'h0);
        check32(rd, 32'hffff_ffff);
        cfg(1'b0, 8'h44, 32'h0);
        check32(rd, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire

//--- verilog/ppsel_defs.svh
// Constants for the power-state and serial-ROM loader block
`ifndef PPSEL_DEFS_SVH
`define PPSEL_DEFS_SVH
`define PPSEL_OFF_CAP      8'h40
`define PPSEL_OFF_CSR      8'h44
`define PPSEL_OFF_USER     8'h48
`define PPSEL_OFF_VENDOR   8'h00
`define PPSEL_OFF_CLASS    8'h08
`define PPSEL_OFF_SUBSYS   8'h2c
`define PPSEL_CAP_VALUE    32'h400a_0001
`define PPSEL_CSR_FLAG_BIT 15
`define PPSEL_CSR_EN_BIT   8
`define PPSEL_PS_D0        2'h0
`define PPSEL_PS_D3HOT     2'h3
`define PPSEL_REV_ID       8'h01
`define PPSEL_VENDOR_DEF   16'h1234 // Arbitrary value, names no maker
`define PPSEL_DEVICE_DEF   16'h5678 // Arbitrary value, names no part
`define PPSEL_CLASS_DEF    24'h070002
`define PPSEL_ROM_WORDS    8
`define PPSEL_ROM_OPCODE   3'h6
`define PPSEL_ROM_ADDR_W   6
`define PPSEL_LOAD_LIMIT   32'h0001_0000
`define PPSEL_SK_DIV       4
`define PPSEL_HOST_OFF_CTRL 12'h000
`define PPSEL_HOST_OFF_ADDR 12'h004
`define PPSEL_HOST_OFF_WDAT 12'h008
`define PPSEL_HOST_OFF_RDAT 12'h00c
`define PPSEL_HOST_OFF_STAT 12'h010
`endif

//--- verilog/ppsel_device.sv
// Device end: power-management registers, wake logic and serial-ROM loader
`timescale 1ns/1ns
`default_nettype none
module ppsel_device
    import ppsel_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Host side
    ppsel_if.dev            bus,
    // Channel events
    input  wire logic [3:0] rx_pin,
    input  wire logic [15:0] modem_delta,
    input  wire logic       int_req,
    output logic            inta_n,
    output logic            func_enable,
    // Serial ROM pins
    input  wire logic       eeprom_select_pin,
    output logic            rom_cs,
    output logic            rom_sk,
    output logic            rom_di,
    input  wire logic       rom_do,
    output logic            load_done
);
`include "ppsel_defs.svh"

    typedef enum logic [4:0] {
        S_IDLE = 5'h01, S_CMD = 5'h02, S_DATA = 5'h04, S_NEXT = 5'h08, S_DONE = 5'h10
    } ppsel_ld_type;

    // Synchronisers for pins from outside the clock domain
    logic [3:0] rx_s1_reg, rx_s2_reg, rx_s3_reg;
    logic       sel_s1_reg, sel_s2_reg, do_s1_reg, do_s2_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_s1_reg  <= 4'hf;
            rx_s2_reg  <= 4'hf;
            rx_s3_reg  <= 4'hf;
            sel_s1_reg <= 1'b0;
            sel_s2_reg <= 1'b0;
            do_s1_reg  <= 1'b0;
            do_s2_reg  <= 1'b0;
        end
        else
        begin
            rx_s1_reg  <= rx_pin;
            rx_s2_reg  <= rx_s1_reg;
            rx_s3_reg  <= rx_s2_reg;
            sel_s1_reg <= eeprom_select_pin;
            sel_s2_reg <= sel_s1_reg;
            do_s1_reg  <= rom_do;
            do_s2_reg  <= do_s1_reg;
        end
    end

    // Power state, wake flag and enable
    ppsel_pstate_type ps_reg;
    logic wake_event_flag_reg, wake_event_enable_reg, oe_hold_reg;
    wire  cfg_wr    = bus.cfg_req & bus.cfg_we;
    wire  wr_csr    = cfg_wr & (bus.cfg_addr == `PPSEL_OFF_CSR);
    wire  in_d3     = (ps_reg == PPSEL_D3HOT);
    wire  rx_start  = |(rx_s3_reg & ~rx_s2_reg);
    wire  wake_evt  = rx_start | (|modem_delta);
    wire  ps_ok     = (bus.cfg_wdata[1:0] == `PPSEL_PS_D0) ||
                      (bus.cfg_wdata[1:0] == `PPSEL_PS_D3HOT);
    wire  clr_flag  = wr_csr & bus.cfg_wdata[`PPSEL_CSR_FLAG_BIT];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ps_reg                <= PPSEL_D0;
            wake_event_flag_reg   <= 1'b0;
            wake_event_enable_reg <= 1'b0;
            oe_hold_reg           <= 1'b0;
        end
        else
        begin
            if (wr_csr && ps_ok)
                ps_reg <= ps_pstate(bus.cfg_wdata[1:0]);
            if (wr_csr)
                wake_event_enable_reg <= bus.cfg_wdata[`PPSEL_CSR_EN_BIT];
            // Set beats clear so no event is lost
            if (in_d3 && wake_evt)
                wake_event_flag_reg <= 1'b1;
            else if (clr_flag)
                wake_event_flag_reg <= 1'b0;
            oe_hold_reg <= wr_csr && ps_ok && in_d3 &&
                           (bus.cfg_wdata[1:0] == `PPSEL_PS_D0);
        end
    end

    function automatic ppsel_pstate_type ps_pstate(input logic [1:0] v);
        ps_pstate = (v == `PPSEL_PS_D3HOT) ? PPSEL_D3HOT : PPSEL_D0;
    endfunction

    // Identity fields, user word loaded only by the ROM engine
    logic [15:0] vendor_reg, device_reg, subven_reg, subsys_reg;
    logic [23:0] class_reg;
    logic [31:0] user_reg;

    // Configuration read mux
    wire [15:0] csr_lo = {wake_event_flag_reg, 6'h00, wake_event_enable_reg, 6'h00, ps_reg};
    logic [31:0] rdata_mux;
    always_comb
    begin
        unique case (bus.cfg_addr)
            `PPSEL_OFF_VENDOR: rdata_mux = {device_reg, vendor_reg};
            `PPSEL_OFF_CLASS:  rdata_mux = {class_reg, `PPSEL_REV_ID};
            `PPSEL_OFF_SUBSYS: rdata_mux = {subsys_reg, subven_reg};
            `PPSEL_OFF_CAP:    rdata_mux = `PPSEL_CAP_VALUE;
            `PPSEL_OFF_CSR:    rdata_mux = {16'h0000, csr_lo};
            `PPSEL_OFF_USER:   rdata_mux = user_reg;
            default:           rdata_mux = 32'h0000_0000;
        endcase
    end

    // Answer stage; config always claimed, memory only in D0
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus.cfg_rdata <= 32'h0000_0000;
            bus.cfg_ack   <= 1'b0;
            bus.mem_ack   <= 1'b0;
        end
        else
        begin
            bus.cfg_ack <= bus.cfg_req & ~bus.cfg_ack;
            bus.mem_ack <= bus.mem_req & ~bus.mem_ack & ~in_d3;
            if (bus.cfg_req && !bus.cfg_we)
                bus.cfg_rdata <= rdata_mux;
        end
    end

    assign bus.pme_n   = ~(in_d3 & wake_event_enable_reg & wake_event_flag_reg);
    assign bus.pci_oe  = ~oe_hold_reg;
    assign inta_n      = ~(int_req & ~in_d3);
    assign func_enable = 1'b1;  // Receive path never gated by power state

    // ROM download engine
    ppsel_ld_type st_reg;
    logic [2:0]  word_reg;
    logic [4:0]  bit_reg;
    logic [15:0] shift_reg;
    logic [8:0]  cmd_reg;
    logic [1:0]  div_reg;
    logic        sk_reg;
    logic [16:0] limit_reg;
    wire  tick    = (div_reg == 2'(`PPSEL_SK_DIV - 1));
    wire  rise    = tick & ~sk_reg;
    wire  fall    = tick & sk_reg;
    wire  timeout = (limit_reg == 17'(`PPSEL_LOAD_LIMIT - 1));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg     <= S_IDLE;
            word_reg   <= 3'h0;
            bit_reg    <= 5'h00;
            shift_reg  <= 16'h0000;
            cmd_reg    <= 9'h000;
            div_reg    <= 2'h0;
            sk_reg     <= 1'b0;
            limit_reg  <= 17'h00000;
            vendor_reg <= `PPSEL_VENDOR_DEF;
            device_reg <= `PPSEL_DEVICE_DEF;
            class_reg  <= `PPSEL_CLASS_DEF;
            subven_reg <= 16'h0000;
            subsys_reg <= 16'h0000;
            user_reg   <= 32'h0000_0000;
        end
        else
        begin
            div_reg <= div_reg + 2'h1;
            if (st_reg != S_DONE)
                limit_reg <= limit_reg + 17'h00001;
            if (tick && (st_reg == S_CMD || st_reg == S_DATA))
                sk_reg <= ~sk_reg;
            unique case (st_reg)
                S_IDLE:
                    // Strap is two flops deep: hold off until it has settled
                    if (limit_reg < 17'h00002)
                        st_reg <= S_IDLE;
                    else if (sel_s2_reg)
                    begin
                        st_reg  <= S_CMD;
                        cmd_reg <= {`PPSEL_ROM_OPCODE, 6'(word_reg)};
                        bit_reg <= 5'd9;
                    end
                    else
                        st_reg <= S_DONE;
                S_CMD:
                    // Bits move on the falling clock so each is steady at the rise
                    if (fall)
                    begin
                        cmd_reg <= {cmd_reg[7:0], 1'b0};
                        bit_reg <= bit_reg - 5'h01;
                        if (bit_reg == 5'h01)
                        begin
                            st_reg  <= S_DATA;
                            bit_reg <= 5'd16;
                        end
                    end
                S_DATA:
                    if (rise)
                    begin
                        shift_reg <= {shift_reg[14:0], do_s2_reg};
                        bit_reg   <= bit_reg - 5'h01;
                        if (bit_reg == 5'h01)
                            st_reg <= S_NEXT;
                    end
                S_NEXT:
                begin
                    unique case (word_reg)
                        3'h0: vendor_reg <= shift_reg;
                        3'h1: device_reg <= shift_reg;
                        3'h2: class_reg[7:0] <= shift_reg[15:8];
                        3'h3: class_reg[23:8] <= shift_reg;
                        3'h4: subven_reg <= shift_reg;
                        3'h5: subsys_reg <= shift_reg;
                        3'h6: user_reg[15:0] <= shift_reg;
                        3'h7: user_reg[31:16] <= shift_reg;
                    endcase
                    sk_reg   <= 1'b0;
                    word_reg <= word_reg + 3'h1;
                    st_reg   <= (word_reg == 3'h7) ? S_DONE : S_IDLE;
                end
                S_DONE: st_reg <= S_DONE;
            endcase
            if (timeout)
                st_reg <= S_DONE;
        end
    end

    assign rom_cs    = (st_reg == S_CMD) | (st_reg == S_DATA);
    assign rom_sk    = sk_reg;
    assign rom_di    = cmd_reg[8] & (st_reg == S_CMD);
    assign load_done = (st_reg == S_DONE);
endmodule
`default_nettype wire

//--- verilog/ppsel_host.sv
// Host end: APB-programmed configuration-cycle master
`timescale 1ns/1ns
`default_nettype none
module ppsel_host
    import ppsel_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Device side
    ppsel_if.host            dev
);
`include "ppsel_defs.svh"

    // Order registers
    logic [7:0]  addr_reg;
    logic [31:0] wdat_reg, rdat_reg;
    logic        busy_reg, we_reg, req_reg;
    logic        mreq_reg, mack_reg;
    wire  apb_wr = psel & penable & pwrite;
    wire  go     = apb_wr & (paddr == `PPSEL_HOST_OFF_CTRL) & ~busy_reg & ~pwdata[1];
    wire  go_mem = apb_wr & (paddr == `PPSEL_HOST_OFF_CTRL) & pwdata[1];
    wire  known  = (paddr == `PPSEL_HOST_OFF_CTRL) | (paddr == `PPSEL_HOST_OFF_ADDR) |
                   (paddr == `PPSEL_HOST_OFF_WDAT) | (paddr == `PPSEL_HOST_OFF_RDAT) |
                   (paddr == `PPSEL_HOST_OFF_STAT);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_reg <= 8'h00;
            wdat_reg <= 32'h0000_0000;
            rdat_reg <= 32'h0000_0000;
            busy_reg <= 1'b0;
            we_reg   <= 1'b0;
            req_reg  <= 1'b0;
            mreq_reg <= 1'b0;
            mack_reg <= 1'b0;
        end
        else
        begin
            // One-cycle memory probe; the answer is kept for status
            mreq_reg <= go_mem;
            if (go_mem)
                mack_reg <= 1'b0;
            else if (dev.mem_ack)
                mack_reg <= 1'b1;
            if (apb_wr && paddr == `PPSEL_HOST_OFF_ADDR)
                addr_reg <= pwdata[7:0];
            if (apb_wr && paddr == `PPSEL_HOST_OFF_WDAT)
                wdat_reg <= pwdata;
            if (go)
            begin
                busy_reg <= 1'b1;
                req_reg  <= 1'b1;
                we_reg   <= pwdata[0];
            end
            // Request held until the device answers
            if (req_reg && dev.cfg_ack)
            begin
                req_reg  <= 1'b0;
                busy_reg <= 1'b0;
                if (!we_reg)
                    rdat_reg <= dev.cfg_rdata;
            end
        end
    end

    // Read mux; status shows busy, wake line and driver enable
    wire [31:0] rmux =
        (paddr == `PPSEL_HOST_OFF_ADDR) ? {24'h000000, addr_reg} :
        (paddr == `PPSEL_HOST_OFF_WDAT) ? wdat_reg :
        (paddr == `PPSEL_HOST_OFF_RDAT) ? rdat_reg :
        (paddr == `PPSEL_HOST_OFF_STAT) ? {28'h0, mack_reg, dev.pci_oe, ~dev.pme_n, busy_reg} :
        32'h0000_0000;
    assign prdata  = rmux;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~known;

    assign dev.cfg_req   = req_reg;
    assign dev.cfg_we    = we_reg;
    assign dev.cfg_addr  = addr_reg;
    assign dev.cfg_wdata = wdat_reg;
    // Memory probe; the device leaves it unanswered while in D3hot
    assign dev.mem_req   = mreq_reg;
endmodule
`default_nettype wire

//--- verilog/ppsel_if.sv
// Carrier joining the configuration host and the device
`timescale 1ns/1ns
`default_nettype none
interface ppsel_if;
    logic       cfg_req;
    logic       cfg_we;
    logic [7:0] cfg_addr;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic       cfg_ack;
    logic       mem_req;
    logic       mem_ack;
    logic       pme_n;
    logic       pci_oe;
    modport dev  (input cfg_req, cfg_we, cfg_addr, cfg_wdata, mem_req,
                  output cfg_rdata, cfg_ack, mem_ack, pme_n, pci_oe);
    modport host (output cfg_req, cfg_we, cfg_addr, cfg_wdata, mem_req,
                  input cfg_rdata, cfg_ack, mem_ack, pme_n, pci_oe);
endinterface
`default_nettype wire

//--- verilog/ppsel_pkg.sv
// Types shared by both ends of the power-state block
package ppsel_pkg;
    typedef enum logic [1:0] {PPSEL_D0 = 2'h0, PPSEL_D3HOT = 2'h3} ppsel_pstate_type;
endpackage
